// ---- core/gcr_pkg.sv ----
// What this block does
// - maintenance error reports pass only when enabled
// - eight-bit device domain, resets to zero
// - port-write priority from bits 14:13, reset zero
// - bit 15 selects small or wide IDs
// - target ID low byte, high byte wide only
// - origin ID low byte, high byte wide only
// - same wide select governs origin high byte
// - assembly maker code and assembly code mirrored
// - assembly revision mirrored, upper half reserved
// - write-only key write resets the whole part
// - boot ROM address resets to pattern plus straps
// - bit 11 set skips image checksum verification
// - divisor converts system clocks to I2C timing
// - divisor above maximum is replaced by maximum
// - bit 25 picks 400 kHz or 100 kHz
package gcr_pkg;
   ////////////////////////////////////////////////////////////////////////////////
   // bus shape
   localparam int ADDR_W = 24;
   localparam int DATA_W = 32;
   localparam int BE_W = 4;
   ////////////////////////////////////////////////////////////////////////////////
   // register byte addresses
   localparam logic [ADDR_W-1:0] OFS_MAINT_GATE = 24'hF2001C;
   localparam logic [ADDR_W-1:0] OFS_DOMAIN = 24'hF20020;
   localparam logic [ADDR_W-1:0] OFS_PW_TARGET = 24'hF20024;
   localparam logic [ADDR_W-1:0] OFS_PW_ORIGIN = 24'hF20028;
   localparam logic [ADDR_W-1:0] OFS_ASSY_IDENT = 24'hF2002C;
   localparam logic [ADDR_W-1:0] OFS_ASSY_REV = 24'hF20030;
   localparam logic [ADDR_W-1:0] OFS_CHIP_RESET = 24'hF20040;
   localparam logic [ADDR_W-1:0] OFS_I2C_SETUP = 24'hF20050;
   ////////////////////////////////////////////////////////////////////////////////
   // writable bit masks, everything else is reserved
   localparam logic [DATA_W-1:0] MASK_MAINT_GATE = 32'h00000001;
   localparam logic [DATA_W-1:0] MASK_DOMAIN = 32'h000000FF;
   localparam logic [DATA_W-1:0] MASK_PW_TARGET = 32'hFFFFE000;
   localparam logic [DATA_W-1:0] MASK_PW_ORIGIN = 32'hFFFF0000;
   localparam logic [DATA_W-1:0] MASK_ASSY_IDENT = 32'hFFFFFFFF;
   localparam logic [DATA_W-1:0] MASK_ASSY_REV = 32'h0000FFFF;
   localparam logic [DATA_W-1:0] MASK_I2C_SETUP = 32'h027F0BFF;
   ////////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int POS_MAINT_GATE = 0;
   localparam int POS_PW_PORT_WRITE_URGENCY_LEVEL_LO = 13;
   localparam int POS_PW_PORT_WRITE_URGENCY_LEVEL_HI = 14;
   localparam int POS_WIDE_ID = 15;
   localparam int POS_ID_LOW_LO = 16;
   localparam int POS_ID_LOW_HI = 23;
   localparam int POS_ID_HIGH_LO = 24;
   localparam int POS_ID_HIGH_HI = 31;
   localparam int POS_ROM_ADDR_HI = 9;
   localparam int POS_SKIP_VERIFY = 11;
   localparam int POS_DIV_LO = 16;
   localparam int POS_DIV_HI = 22;
   localparam int POS_SPEED_SEL = 25;
   ////////////////////////////////////////////////////////////////////////////////
   // reset values and special figures
   localparam logic [DATA_W-1:0] RST_ZERO = 32'h00000000;
   localparam logic [9:0] RST_ROM_ADDR = 10'h050;
   localparam int STRAP_W = 3;
   localparam logic [6:0] DIV_MAX = 7'h62;
   localparam logic [6:0] DIV_MIN = 7'h31;
   localparam logic [DATA_W-1:0] CHIP_RESET_KEY = 32'h00030097;
   localparam logic [1:0] STRAP_SETTLE = 2'h2;
   ////////////////////////////////////////////////////////////////////////////////
   // carriers
   typedef struct packed {
      logic [1:0] urgency;
      logic wide_id;
      logic [15:0] destination;
      logic [15:0] origin;
   } gcr_pw_s;

   typedef struct packed {
      logic [15:0] maker_code;
      logic [15:0] assembly_code;
      logic [15:0] revision;
   } gcr_assy_s;

   typedef struct packed {
      logic [9:0] rom_address;
      logic skip_verify;
      logic [6:0] ratio;
      logic slow_speed;
   } gcr_i2c_s;

   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_ANSWER = 1'b1
   } gcr_bus_e;
endpackage : gcr_pkg

// ---- core/gcr_global_config.sv ----
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ns
module gcr_global_config
   import gcr_pkg::*;
(
   // clock and reset
   input wire logic clock_in,
   input wire logic reset_n_in,
   // avalon-mm slave
   input wire logic [ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [DATA_W-1:0] avs_writedata_in,
   input wire logic [BE_W-1:0] avs_byteenable_in,
   output logic [DATA_W-1:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // address straps, static pins
   input wire logic [STRAP_W-1:0] addr_strap_in,
   // maintenance module error events
   input wire logic maint_error_in,
   output logic maint_error_report_out,
   // configuration toward the rest of the part
   output logic [7:0] device_domain_out,
   output gcr_pw_s port_write_out,
   output gcr_assy_s assembly_out,
   output gcr_i2c_s i2c_setup_out,
   output logic i2c_time_tick_out,
   output logic chip_reset_out
);
   ////////////////////////////////////////////////////////////////////////////////
   // storage
   logic [DATA_W-1:0] maint_error_report_gate_q;
   logic [DATA_W-1:0] device_domain_q;
   logic [DATA_W-1:0] port_write_target_info_q;
   logic [DATA_W-1:0] port_write_origin_q;
   logic [DATA_W-1:0] assembly_identity_source_q;
   logic [DATA_W-1:0] assembly_revision_source_q;
   logic [DATA_W-1:0] i2c_master_setup_q;

   // bus answer
   gcr_bus_e bus_state_q;
   logic [DATA_W-1:0] readdata_q;
   logic waitrequest_q;

   // strap capture, loaded once after reset
   logic [STRAP_W-1:0] strap_meta_q;
   logic [STRAP_W-1:0] strap_sync_q;
   logic [1:0] strap_count_q;
   logic strap_done_q;
   logic rom_addr_written_q;

   // time base and pulses
   logic [6:0] ratio_count_q;
   logic tick_q;
   logic chip_reset_q;
   logic maint_report_q;

   // output images
   logic [7:0] domain_out_q;
   gcr_pw_s pw_q;
   gcr_assy_s assy_q;
   gcr_i2c_s i2c_q;

   ////////////////////////////////////////////////////////////////////////////////
   // bus decode
   logic request;
   logic commit;
   logic wr_commit;
   logic [DATA_W-1:0] be_mask;
   logic [DATA_W-1:0] read_mux;
   logic [6:0] ratio_used;
   logic strap_load;

   assign request = avs_read_in | avs_write_in;
   // the access completes at the edge where waitrequest is seen low
   assign commit = request && (bus_state_q == BUS_ANSWER);
   assign wr_commit = commit && avs_write_in;

   always_comb begin
      for (int i = 0; i < BE_W; i++) begin
         be_mask[i*8 +: 8] = {8{avs_byteenable_in[i]}};
      end
   end

   function automatic logic [DATA_W-1:0] merge(
      input logic [DATA_W-1:0] old_value,
      input logic [DATA_W-1:0] new_value,
      input logic [DATA_W-1:0] lane_mask,
      input logic [DATA_W-1:0] field_mask
   );
      logic [DATA_W-1:0] take;
      take = lane_mask & field_mask;
      merge = (old_value & ~take) | (new_value & take);
   endfunction : merge

   always_comb begin
      read_mux = RST_ZERO;
      unique case (avs_address_in)
         OFS_MAINT_GATE: read_mux = maint_error_report_gate_q;
         OFS_DOMAIN: read_mux = device_domain_q;
         OFS_PW_TARGET: read_mux = port_write_target_info_q;
         OFS_PW_ORIGIN: read_mux = port_write_origin_q;
         OFS_ASSY_IDENT: read_mux = assembly_identity_source_q;
         OFS_ASSY_REV: read_mux = assembly_revision_source_q;
         // write-only key register reads as zero
         OFS_CHIP_RESET: read_mux = RST_ZERO;
         OFS_I2C_SETUP: read_mux = i2c_master_setup_q;
         default: read_mux = RST_ZERO;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // avalon handshake: one wait cycle, then answer
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         bus_state_q <= BUS_IDLE;
         waitrequest_q <= 1'b1;
         readdata_q <= RST_ZERO;
      end else begin
         unique case (bus_state_q)
            BUS_IDLE: begin
               if (request) begin
                  bus_state_q <= BUS_ANSWER;
                  waitrequest_q <= 1'b0;
                  readdata_q <= avs_read_in ? read_mux : RST_ZERO;
               end
            end
            BUS_ANSWER: begin
               bus_state_q <= BUS_IDLE;
               waitrequest_q <= 1'b1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // plain configuration registers
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         maint_error_report_gate_q <= RST_ZERO;
      end else if (wr_commit && avs_address_in == OFS_MAINT_GATE) begin
         maint_error_report_gate_q <= merge(maint_error_report_gate_q, avs_writedata_in,
                                            be_mask, MASK_MAINT_GATE);
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         device_domain_q <= RST_ZERO;
      end else if (wr_commit && avs_address_in == OFS_DOMAIN) begin
         device_domain_q <= merge(device_domain_q, avs_writedata_in, be_mask,
                                  MASK_DOMAIN);
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         port_write_target_info_q <= RST_ZERO;
      end else if (wr_commit && avs_address_in == OFS_PW_TARGET) begin
         port_write_target_info_q <= merge(port_write_target_info_q, avs_writedata_in,
                                           be_mask, MASK_PW_TARGET);
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         port_write_origin_q <= RST_ZERO;
      end else if (wr_commit && avs_address_in == OFS_PW_ORIGIN) begin
         port_write_origin_q <= merge(port_write_origin_q, avs_writedata_in,
                                      be_mask, MASK_PW_ORIGIN);
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         assembly_identity_source_q <= RST_ZERO;
      end else if (wr_commit && avs_address_in == OFS_ASSY_IDENT) begin
         assembly_identity_source_q <= merge(assembly_identity_source_q, avs_writedata_in,
                                             be_mask, MASK_ASSY_IDENT);
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         assembly_revision_source_q <= RST_ZERO;
      end else if (wr_commit && avs_address_in == OFS_ASSY_REV) begin
         assembly_revision_source_q <= merge(assembly_revision_source_q, avs_writedata_in,
                                             be_mask, MASK_ASSY_REV);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // strap capture: pins are synchronised, then loaded once after release
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         strap_meta_q <= '0;
         strap_sync_q <= '0;
      end else begin
         strap_meta_q <= addr_strap_in;
         strap_sync_q <= strap_meta_q;
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         strap_count_q <= '0;
         strap_done_q <= 1'b0;
      end else if (!strap_done_q) begin
         if (strap_count_q == STRAP_SETTLE) begin
            strap_done_q <= 1'b1;
         end else begin
            strap_count_q <= strap_count_q + 2'h1;
         end
      end
   end

   // the single edge at which the synchronised straps enter the address field
   assign strap_load = strap_count_q == STRAP_SETTLE && !strap_done_q && !rom_addr_written_q;

   // a software write before the straps settle wins over the strap load
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rom_addr_written_q <= 1'b0;
      end else if (wr_commit && avs_address_in == OFS_I2C_SETUP &&
                   (avs_byteenable_in[0] | avs_byteenable_in[1])) begin
         rom_addr_written_q <= 1'b1;
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         i2c_master_setup_q <= RST_ZERO;
         i2c_master_setup_q[POS_ROM_ADDR_HI:0] <= RST_ROM_ADDR;
         i2c_master_setup_q[POS_DIV_HI:POS_DIV_LO] <= DIV_MAX;
      end else if (wr_commit && avs_address_in == OFS_I2C_SETUP) begin
         i2c_master_setup_q <= merge(i2c_master_setup_q, avs_writedata_in,
                                     be_mask, MASK_I2C_SETUP);
         // an upper-lanes write on the load edge must not swallow the straps
         if (strap_load && !avs_byteenable_in[0] && !avs_byteenable_in[1]) begin
            i2c_master_setup_q[STRAP_W-1:0] <= strap_sync_q;
         end
      end else if (strap_load) begin
         i2c_master_setup_q[STRAP_W-1:0] <= strap_sync_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // keyed chip reset: exact full-word key only, all lanes enabled
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         chip_reset_q <= 1'b0;
      end else begin
         chip_reset_q <= wr_commit && avs_address_in == OFS_CHIP_RESET &&
                         (&avs_byteenable_in) &&
                         avs_writedata_in == CHIP_RESET_KEY;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // effective divisor: programmed value above the maximum is clamped
   always_comb begin
      ratio_used = i2c_master_setup_q[POS_DIV_HI:POS_DIV_LO];
      if (ratio_used > DIV_MAX) begin
         ratio_used = DIV_MAX;
      end
   end

   // time base tick every ratio_used clocks; values below the minimum are not
   // guarded, software keeps to it
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ratio_count_q <= '0;
         tick_q <= 1'b0;
      end else if (ratio_count_q + 7'h01 >= ratio_used) begin
         ratio_count_q <= '0;
         tick_q <= 1'b1;
      end else begin
         ratio_count_q <= ratio_count_q + 7'h01;
         tick_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // error gate
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         maint_report_q <= 1'b0;
      end else begin
         maint_report_q <= maint_error_in &
                           maint_error_report_gate_q[POS_MAINT_GATE];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registered configuration outputs, one cycle behind the registers
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         domain_out_q <= '0;
      end else begin
         domain_out_q <= device_domain_q[7:0];
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pw_q <= '0;
      end else begin
         pw_q.urgency <= port_write_target_info_q[POS_PW_PORT_WRITE_URGENCY_LEVEL_HI:POS_PW_PORT_WRITE_URGENCY_LEVEL_LO];
         pw_q.wide_id <= port_write_target_info_q[POS_WIDE_ID];
         pw_q.destination[7:0] <=
            port_write_target_info_q[POS_ID_LOW_HI:POS_ID_LOW_LO];
         // high bytes are forced to zero in small transport
         pw_q.destination[15:8] <= port_write_target_info_q[POS_WIDE_ID] ?
            port_write_target_info_q[POS_ID_HIGH_HI:POS_ID_HIGH_LO] : 8'h00;
         pw_q.origin[7:0] <= port_write_origin_q[POS_ID_LOW_HI:POS_ID_LOW_LO];
         pw_q.origin[15:8] <= port_write_target_info_q[POS_WIDE_ID] ?
            port_write_origin_q[POS_ID_HIGH_HI:POS_ID_HIGH_LO] : 8'h00;
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         assy_q <= '0;
      end else begin
         assy_q.maker_code <= assembly_identity_source_q[15:0];
         assy_q.assembly_code <= assembly_identity_source_q[31:16];
         assy_q.revision <= assembly_revision_source_q[15:0];
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         i2c_q.rom_address <= RST_ROM_ADDR;
         i2c_q.skip_verify <= 1'b0;
         i2c_q.ratio <= DIV_MAX;
         i2c_q.slow_speed <= 1'b0;
      end else begin
         i2c_q.rom_address <= i2c_master_setup_q[POS_ROM_ADDR_HI:0];
         i2c_q.skip_verify <= i2c_master_setup_q[POS_SKIP_VERIFY];
         i2c_q.ratio <= ratio_used;
         i2c_q.slow_speed <= i2c_master_setup_q[POS_SPEED_SEL];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs
   assign avs_readdata_out = readdata_q;
   assign avs_waitrequest_out = waitrequest_q;
   assign maint_error_report_out = maint_report_q;
   assign device_domain_out = domain_out_q;
   assign port_write_out = pw_q;
   assign assembly_out = assy_q;
   assign i2c_setup_out = i2c_q;
   assign i2c_time_tick_out = tick_q;
   assign chip_reset_out = chip_reset_q;
endmodule : gcr_global_config

// ---- test/gcr_global_config_properties.sv ----
`timescale 1ns/1ns
module gcr_global_config_properties
   import gcr_pkg::*;
(
   // clock and reset
   input wire logic clock_in,
   input wire logic reset_n_in,
   // register bus
   input wire logic [ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [DATA_W-1:0] avs_writedata_in,
   input wire logic [BE_W-1:0] avs_byteenable_in,
   input wire logic [DATA_W-1:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   // straps and events
   input wire logic [STRAP_W-1:0] addr_strap_in,
   input wire logic maint_error_in,
   input wire logic maint_error_report_out,
   // configuration outputs
   input wire logic [7:0] device_domain_out,
   input wire gcr_pw_s port_write_out,
   input wire gcr_assy_s assembly_out,
   input wire gcr_i2c_s i2c_setup_out,
   input wire logic i2c_time_tick_out,
   input wire logic chip_reset_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!reset_n_in);
   logic ans_rd;
   logic ans_wr;
   logic key_wr;
   assign ans_rd = avs_read_in && !avs_waitrequest_out;
   assign ans_wr = avs_write_in && !avs_waitrequest_out;
   assign key_wr = ans_wr && avs_address_in == OFS_CHIP_RESET &&
      avs_writedata_in == CHIP_RESET_KEY && avs_byteenable_in == 4'hF;
   ////////////////////////////////////////////////////////////////////////////////
   property p_report_cause;
      maint_error_report_out |-> $past(maint_error_in);
   endproperty
   a_report_cause: assert property (p_report_cause) else $error("report without event");
   property p_dest_high;
      !port_write_out.wide_id |-> port_write_out.destination[15:8] == 8'h00;
   endproperty
   a_dest_high: assert property (p_dest_high) else $error("target high byte leaks");
   property p_orig_high;
      !port_write_out.wide_id |-> port_write_out.origin[15:8] == 8'h00;
   endproperty
   a_orig_high: assert property (p_orig_high) else $error("origin high byte leaks");
   property p_ratio_clamp;
      i2c_setup_out.ratio <= DIV_MAX;
   endproperty
   a_ratio_clamp: assert property (p_ratio_clamp) else $error("divisor above max");
   property p_key_pulse;
      $rose(chip_reset_out) |-> $past(key_wr) || $past(key_wr, 2);
   endproperty
   a_key_pulse: assert property (p_key_pulse) else $error("reset without key");
   property p_pulse_short;
      chip_reset_out |=> !chip_reset_out;
   endproperty
   a_pulse_short: assert property (p_pulse_short) else $error("reset pulse too long");
   property p_domain_cause;
      $changed(device_domain_out) |-> $past(ans_wr && avs_address_in == OFS_DOMAIN, 2);
   endproperty
   a_domain_cause: assert property (p_domain_cause) else $error("domain moved alone");
   property p_domain_rsv;
      ans_rd && avs_address_in == OFS_DOMAIN |-> avs_readdata_out[31:8] == 24'h000000;
   endproperty
   a_domain_rsv: assert property (p_domain_rsv) else $error("domain reserved set");
   property p_i2c_rsv;
      ans_rd && avs_address_in == OFS_I2C_SETUP |-> (avs_readdata_out & ~MASK_I2C_SETUP) == 32'h0;
   endproperty
   a_i2c_rsv: assert property (p_i2c_rsv) else $error("i2c reserved set");
   property p_key_reads_zero;
      ans_rd && avs_address_in == OFS_CHIP_RESET |-> avs_readdata_out == RST_ZERO;
   endproperty
   a_key_reads_zero: assert property (p_key_reads_zero) else $error("key readable");
   property p_one_wait;
      !avs_waitrequest_out |=> avs_waitrequest_out;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("answer held too long");
   c_key: cover property (chip_reset_out);
   c_wide: cover property (port_write_out.wide_id);
   c_tick: cover property (i2c_time_tick_out);
endmodule : gcr_global_config_properties

bind gcr_global_config gcr_global_config_properties gcr_global_config_properties_i (
   .clock_in(clock_in), .reset_n_in(reset_n_in), .avs_address_in(avs_address_in),
   .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
   .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
   .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
   .addr_strap_in(addr_strap_in), .maint_error_in(maint_error_in),
   .maint_error_report_out(maint_error_report_out), .device_domain_out(device_domain_out),
   .port_write_out(port_write_out), .assembly_out(assembly_out),
   .i2c_setup_out(i2c_setup_out), .i2c_time_tick_out(i2c_time_tick_out),
   .chip_reset_out(chip_reset_out));

// ---- test/gcr_global_config_tb.sv ----
`timescale 1ns/1ns
module gcr_global_config_tb;
   import gcr_pkg::*;
   logic clock_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic [ADDR_W-1:0] avs_address_in = '0;
   logic avs_read_in = 1'b0;
   logic avs_write_in = 1'b0;
   logic [DATA_W-1:0] avs_writedata_in = '0;
   logic [BE_W-1:0] avs_byteenable_in = '0;
   logic [DATA_W-1:0] avs_readdata_out;
   logic avs_waitrequest_out;
   logic [STRAP_W-1:0] addr_strap_in = 3'h5;
   logic maint_error_in = 1'b0;
   logic maint_error_report_out;
   logic [7:0] device_domain_out;
   gcr_pw_s port_write_out;
   gcr_assy_s assembly_out;
   gcr_i2c_s i2c_setup_out;
   logic i2c_time_tick_out;
   logic chip_reset_out;
   int err_total = 0;
   int samples_checked = 0;
   int pulses = 0;
   logic [31:0] rd;
   always #50 clock_in = ~clock_in;
   always @(posedge clock_in) if (chip_reset_out === 1'b1) pulses <= pulses + 1;
   gcr_global_config gcr_global_config_i (
      .clock_in(clock_in), .reset_n_in(reset_n_in), .avs_address_in(avs_address_in),
      .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
      .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
      .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
      .addr_strap_in(addr_strap_in), .maint_error_in(maint_error_in),
      .maint_error_report_out(maint_error_report_out), .device_domain_out(device_domain_out),
      .port_write_out(port_write_out), .assembly_out(assembly_out),
      .i2c_setup_out(i2c_setup_out), .i2c_time_tick_out(i2c_time_tick_out),
      .chip_reset_out(chip_reset_out));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         err_total++;
      end
   endtask : chk
   // one request, held until waitrequest is seen low at a rising edge, released at that edge
   task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      input logic [BE_W-1:0] be);
      int n;
      @(posedge clock_in);
      avs_address_in <= a;
      avs_write_in <= w;
      avs_read_in <= !w;
      avs_writedata_in <= d;
      avs_byteenable_in <= be;
      n = 0;
      do begin
         @(posedge clock_in);
         n++;
      end while (avs_waitrequest_out !== 1'b0 && n < 20);
      if (avs_waitrequest_out !== 1'b0) begin
         chk(avs_waitrequest_out, 1'b0);
         stop_test();
      end
      rd = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
   endtask : bus
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] be);
      bus(1'b1, a, d, be);
   endtask : wr
   task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0, 4'hF);
      chk(rd, exp);
   endtask : rdc
   // outputs mirror the register one clock after the write lands
   task automatic settle();
      repeat (2) @(negedge clock_in);
   endtask : settle
   task automatic tick_gap(input int exp);
      int n;
      repeat (3) begin
         n = 0;
         do begin
            @(negedge clock_in);
            n++;
         end while (i2c_time_tick_out !== 1'b1 && n < 300);
         if (i2c_time_tick_out !== 1'b1) begin
            chk(i2c_time_tick_out, 1'b1);
            stop_test();
         end
      end
      chk(n, exp);
   endtask : tick_gap
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rdc(OFS_MAINT_GATE, 32'h00000000);
      rdc(OFS_DOMAIN, 32'h00000000);
      rdc(OFS_PW_TARGET, 32'h00000000);
      rdc(OFS_I2C_SETUP, 32'h00620055);
      chk(i2c_setup_out, {10'h055, 1'b0, 7'h62, 1'b0});
   endtask : t_reset
   task automatic t_gate();
      @(posedge clock_in);
      maint_error_in <= 1'b1;
      settle();
      chk(maint_error_report_out, 1'b0);
      wr(OFS_MAINT_GATE, 32'hFFFFFFFF, 4'hF);
      settle();
      chk(maint_error_report_out, 1'b1);
      rdc(OFS_MAINT_GATE, 32'h00000001);
      @(posedge clock_in);
      maint_error_in <= 1'b0;
      settle();
      chk(maint_error_report_out, 1'b0);
   endtask : t_gate
   task automatic t_port_write();
      wr(OFS_PW_TARGET, 32'hA5C3FFFF, 4'hF);
      wr(OFS_PW_ORIGIN, 32'h5A3CFFFF, 4'hF);
      rdc(OFS_PW_TARGET, 32'hA5C3E000);
      rdc(OFS_PW_ORIGIN, 32'h5A3C0000);
      settle();
      chk(port_write_out, {2'h3, 1'b1, 16'hA5C3, 16'h5A3C});
      wr(OFS_PW_TARGET, 32'h00004000, 4'h3);
      settle();
      chk(port_write_out, {2'h2, 1'b0, 16'h00C3, 16'h003C});
   endtask : t_port_write
   task automatic t_assembly_domain();
      wr(OFS_ASSY_IDENT, 32'h12345678, 4'hF);
      wr(OFS_ASSY_REV, 32'hFFFF9ABC, 4'hF);
      rdc(OFS_ASSY_REV, 32'h00009ABC);
      rdc(OFS_ASSY_IDENT, 32'h12345678);
      wr(OFS_DOMAIN, 32'hFFFFFF77, 4'hF);
      wr(OFS_DOMAIN, 32'h000000AA, 4'hE);
      rdc(OFS_DOMAIN, 32'h00000077);
      settle();
      chk(assembly_out, {16'h5678, 16'h1234, 16'h9ABC});
      chk(device_domain_out, 8'h77);
   endtask : t_assembly_domain
   task automatic t_i2c();
      wr(OFS_I2C_SETUP, 32'hFFFFFFFF, 4'hF);
      rdc(OFS_I2C_SETUP, 32'h027F0BFF);
      settle();
      chk(i2c_setup_out, {10'h3FF, 1'b1, 7'h62, 1'b1});
      tick_gap(98);
      wr(OFS_I2C_SETUP, 32'h00310000, 4'hF);
      settle();
      chk(i2c_setup_out, {10'h000, 1'b0, 7'h31, 1'b0});
      tick_gap(49);
   endtask : t_i2c
   task automatic t_key();
      int p;
      p = pulses;
      wr(OFS_CHIP_RESET, 32'h00030096, 4'hF);
      wr(OFS_CHIP_RESET, CHIP_RESET_KEY, 4'h7);
      settle();
      chk(pulses, p);
      wr(OFS_CHIP_RESET, CHIP_RESET_KEY, 4'hF);
      settle();
      chk(pulses, p + 1);
      rdc(OFS_CHIP_RESET, 32'h00000000);
      wr(24'hF20060, 32'hFFFFFFFF, 4'hF);
      rdc(24'hF20060, 32'h00000000);
   endtask : t_key
   initial begin
      repeat (12) @(posedge clock_in);
      reset_n_in <= 1'b1;
      // straps need three edges before they show in the address field
      repeat (6) @(posedge clock_in);
      t_reset();
      t_gate();
      t_port_write();
      t_assembly_domain();
      t_i2c();
      t_key();
      stop_test();
   end
endmodule : gcr_global_config_tb
